// ---- hw/spkl_core.sv ----
// slider position and dominant key lockout, run once per acquisition cycle
// assumes detect flags and deltas are stable while sample_valid_in is high
`timescale 1ns/1ps
module spkl_core #(
    parameter int DELTA_W = spkl_pkg::DELTA_W
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic sample_valid_in,
    input wire logic [15:0] key_detect_in,
    input wire logic [15:0][DELTA_W-1:0] key_delta_in,
    input wire spkl_pkg::spkl_key_cfg_type [15:0] key_cfg_in,
    input wire logic slider_enable_in,
    input wire logic [3:0] slider_keys_in,
    input wire logic [3:0] slider_res_bits_in,
    output logic [15:0] key_state_out,
    output spkl_pkg::spkl_slider_type slider_out,
    output logic report_valid_out
);
    localparam int NG = spkl_pkg::NUM_GROUPS;

    function automatic logic [3:0] clamp4(input logic [3:0] v, input int lo, input int hi);
        logic [3:0] r;
        r = v;
        if (v < 4'(lo)) begin
            r = 4'(lo);
        end else if (v > 4'(hi)) begin
            r = 4'(hi);
        end
        return r;
    endfunction

    function automatic logic [2:0] count_grants(input logic [15:0] hits);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 16; i++) begin
            if (hits[i] && n != 3'h7) begin
                n = n + 3'h1;
            end
        end
        return n;
    endfunction

    // decoding of configuration
    wire [3:0] slider_count_w = clamp4(slider_keys_in, spkl_pkg::SLIDER_MIN_KEYS,
        spkl_pkg::SLIDER_MAX_KEYS);
    wire [3:0] res_bits_w = clamp4(slider_res_bits_in, spkl_pkg::RES_MIN_BITS,
        spkl_pkg::RES_MAX_BITS);
    wire [8:0] max_val_w = 9'((9'h001 << res_bits_w) - 9'h001);
    // the slider borrows its group from its first key; mixed groups are not merged
    wire [1:0] slider_group_w = key_cfg_in[0].group;
    logic [15:0] enabled_w;
    logic [15:0] range_w;
    logic [15:0] member_w;
    logic [15:0] raw_w;

    for (genvar i = 0; i < 16; i++) begin : g_key
        assign enabled_w[i] = |key_cfg_in[i].burst_length_setting;
        // key i on line zero sits at drive line i
        assign range_w[i] = slider_enable_in && (i < spkl_pkg::LINE_KEYS)
            && (4'(i) < slider_count_w);
    end

    assign member_w = range_w & enabled_w;
    assign raw_w = key_detect_in & enabled_w;
    wire slider_raw_w = |(raw_w & member_w);

    // strongest member delta stands for the slider when picking a dominant object
    logic [DELTA_W-1:0] slider_delta_w;
    always_comb begin
        slider_delta_w = '0;
        for (int i = 0; i < spkl_pkg::LINE_KEYS; i++) begin
            if (raw_w[i] && member_w[i] && key_delta_in[i] > slider_delta_w) begin
                slider_delta_w = key_delta_in[i];
            end
        end
    end

    // lockout per group
    spkl_pkg::spkl_lock_type lock_reg [NG];
    spkl_pkg::spkl_lock_type lock_next [NG];
    logic [NG-1:0] owner_live_w;

    always_comb begin
        for (int g = 0; g < NG; g++) begin
            logic [1:0] grp;
            logic [4:0] own;
            logic [DELTA_W-1:0] best;
            grp = 2'(g + 1);
            own = lock_reg[g].owner;
            best = '0;
            if (own == spkl_pkg::SLIDER_ID) begin
                owner_live_w[g] = lock_reg[g].held && slider_raw_w
                    && slider_group_w == grp;
            end else begin
                owner_live_w[g] = lock_reg[g].held && raw_w[own[3:0]] && !member_w[own[3:0]]
                    && key_cfg_in[own[3:0]].group == grp;
            end
            lock_next[g] = '{held: 1'b0, owner: spkl_pkg::OWNER_RESET};
            if (owner_live_w[g]) begin
                lock_next[g] = lock_reg[g];
            end else begin
                // new pick: the largest delta wins, the lower key number on a tie
                for (int i = 0; i < 16; i++) begin
                    if (raw_w[i] && !member_w[i] && key_cfg_in[i].group == grp
                        && (!lock_next[g].held || key_delta_in[i] > best)) begin
                        lock_next[g] = '{held: 1'b1, owner: 5'(i)};
                        best = key_delta_in[i];
                    end
                end
                if (slider_raw_w && slider_group_w == grp
                    && (!lock_next[g].held || slider_delta_w > best)) begin
                    lock_next[g] = '{held: 1'b1, owner: spkl_pkg::SLIDER_ID};
                end
            end
        end
    end

    // reporting
    logic [15:0] key_grant_w;
    logic slider_grant_w;

    always_comb begin
        slider_grant_w = slider_raw_w && (slider_group_w == spkl_pkg::GROUP_EXEMPT
            || (lock_next[slider_group_w - 2'h1].held
            && lock_next[slider_group_w - 2'h1].owner == spkl_pkg::SLIDER_ID));
        for (int i = 0; i < 16; i++) begin
            logic [1:0] kg;
            kg = key_cfg_in[i].group;
            if (kg == spkl_pkg::GROUP_EXEMPT) begin
                key_grant_w[i] = raw_w[i] && !member_w[i];
            end else begin
                key_grant_w[i] = raw_w[i] && !member_w[i] && lock_next[kg - 2'h1].held
                    && lock_next[kg - 2'h1].owner == 5'(i);
            end
        end
    end

    // members are never locked against each other, only the object as a whole
    wire [15:0] state_next = key_grant_w | (slider_grant_w ? (raw_w & member_w) : 16'h0000);

    // position: delta weighted centroid of the slider keys, scaled to the range
    logic [31:0] pos_num_w;
    logic [31:0] pos_den_w;
    logic [31:0] pos_q_w;

    always_comb begin
        logic [31:0] wsum;
        logic [31:0] dsum;
        wsum = 32'h0000_0000;
        dsum = 32'h0000_0000;
        for (int i = 0; i < spkl_pkg::LINE_KEYS; i++) begin
            if (member_w[i]) begin
                wsum = wsum + 32'(i) * 32'(key_delta_in[i]);
                dsum = dsum + 32'(key_delta_in[i]);
            end
        end
        pos_num_w = wsum * 32'(max_val_w);
        pos_den_w = dsum * 32'(slider_count_w - 4'h1);
        pos_q_w = (pos_den_w == 32'h0000_0000) ? 32'h0000_0000 : pos_num_w / pos_den_w;
    end

    // a large integer divider sits in one cycle; acquisition cycles are far apart
    wire [7:0] pos_next = (pos_q_w > 32'(max_val_w)) ? max_val_w[7:0] : pos_q_w[7:0];

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int g = 0; g < NG; g++) begin
                lock_reg[g] <= '{held: 1'b0, owner: spkl_pkg::OWNER_RESET};
            end
        end else if (sample_valid_in) begin
            for (int g = 0; g < NG; g++) begin
                lock_reg[g] <= lock_next[g];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            key_state_out <= 16'h0000;
            slider_out <= '{touched: 1'b0, position: spkl_pkg::POS_RESET};
            report_valid_out <= 1'b0;
        end else begin
            report_valid_out <= sample_valid_in;
            if (sample_valid_in) begin
                key_state_out <= state_next;
                slider_out.touched <= slider_grant_w;
                if (slider_grant_w) begin
                    slider_out.position <= pos_next;
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    logic [15:0] exempt_w;
    logic [15:0] same_grp_w;
    for (genvar i = 0; i < 16; i++) begin : g_exempt
        assign exempt_w[i] = key_cfg_in[i].group == spkl_pkg::GROUP_EXEMPT && !member_w[i];
        assign same_grp_w[i] = key_cfg_in[i].group == slider_group_w;
    end

    for (genvar g = 0; g < NG; g++) begin : g_chk
        logic [15:0] hits_w;
        for (genvar i = 0; i < 16; i++) begin : g_hit
            assign hits_w[i] = key_grant_w[i] && key_cfg_in[i].group == 2'(g + 1);
        end
        wire [2:0] objs_w = count_grants(hits_w) + ((slider_grant_w
            && slider_group_w == 2'(g + 1)) ? 3'h1 : 3'h0);

        a_one_per_group: assert property (
            sample_valid_in |-> objs_w <= 3'h1)
            else $error("more than one object reported in a lockout group");

        a_latch_holds: assert property (
            sample_valid_in && owner_live_w[g] |=> lock_reg[g] == $past(lock_reg[g]))
            else $error("dominant owner changed while still in detect");
    end

    a_exempt_pass: assert property (
        sample_valid_in |=> (key_state_out & $past(exempt_w)) == $past(raw_w & exempt_w))
        else $error("exempt key report differs from its detect");

    a_disabled_quiet: assert property (
        sample_valid_in |=> (key_state_out & ~$past(enabled_w)) == 16'h0000)
        else $error("disabled key reported in detect");

    a_members_free: assert property (
        sample_valid_in && slider_grant_w
        |=> (key_state_out & $past(member_w)) == $past(raw_w & member_w) && slider_out.touched)
        else $error("slider members suppressed each other");

    a_slider_span: assert property (
        range_w[15:8] == 8'h00 && (!slider_enable_in || (range_w[0] && range_w[1])))
        else $error("slider span does not start at key zero on line zero");

    // a run of ones from bit zero carries into no set bit when one is added
    a_slider_contig: assert property (
        (range_w & (range_w + 16'h0001)) == 16'h0000)
        else $error("slider keys are not consecutive");

    a_slider_len: assert property (
        slider_enable_in |-> 4'($countones(range_w)) == slider_count_w)
        else $error("slider length differs from the programmed count");

    a_slider_locks_keys: assert property (
        sample_valid_in && slider_grant_w && slider_group_w != spkl_pkg::GROUP_EXEMPT
        |=> (key_state_out & $past(same_grp_w & ~member_w)) == 16'h0000)
        else $error("key reported while the slider holds its group");

    a_key_first_wins: assert property (
        sample_valid_in && slider_group_w != spkl_pkg::GROUP_EXEMPT
        && owner_live_w[slider_group_w - 2'h1]
        && lock_reg[slider_group_w - 2'h1].owner != spkl_pkg::SLIDER_ID |=> !slider_out.touched)
        else $error("slider reported over a dominant key of its group");

    a_res_clamp: assert property (
        max_val_w >= 9'h003 && max_val_w <= 9'h0FF)
        else $error("position range outside two to eight bits");

    a_grant_detect: assert property (
        (key_grant_w & ~raw_w) == 16'h0000)
        else $error("key granted without an enabled detect");

    a_slider_size: assert property (
        slider_enable_in |-> $countones(range_w) >= 2 && $countones(range_w) <= 8)
        else $error("slider holds fewer than two or more than eight keys");

    a_pos_range: assert property (
        sample_valid_in && slider_grant_w |=> 9'(slider_out.position) <= $past(max_val_w))
        else $error("position beyond the configured range");

    a_pos_hold: assert property (
        sample_valid_in && !slider_raw_w
        |=> !slider_out.touched && $stable(slider_out.position))
        else $error("untouched slider changed its position");

    c_slider_two_keys: cover property (
        sample_valid_in && slider_grant_w && $countones(raw_w & member_w) >= 2);
    c_key_blocks_slider: cover property (
        sample_valid_in && slider_raw_w && !slider_grant_w);
    c_full_range: cover property (
        sample_valid_in ##1 slider_out.touched && slider_out.position == 8'hFF);
    c_slider_locks_key: cover property (sample_valid_in && slider_grant_w
        && slider_group_w != spkl_pkg::GROUP_EXEMPT && |(raw_w & same_grp_w & ~member_w));
endmodule

// ---- hw/spkl_pkg.sv ----
// constants and carrier types for the slider position and key lockout block
// assumes a single clock domain; no registers are reachable over a bus
package spkl_pkg;
    localparam int NUM_KEYS = 16;
    localparam int LINE_KEYS = 8;
    localparam int SLIDER_MIN_KEYS = 2;
    localparam int SLIDER_MAX_KEYS = 8;
    localparam int NUM_GROUPS = 3;
    localparam int DELTA_W = 16;
    localparam int BURST_W = 4;
    localparam int POS_W = 8;
    localparam int RES_MIN_BITS = 2;
    localparam int RES_MAX_BITS = 8;
    localparam logic [1:0] GROUP_EXEMPT = 2'h0;
    localparam logic [4:0] SLIDER_ID = 5'h10;
    localparam logic [4:0] OWNER_RESET = 5'h00;
    localparam logic [7:0] POS_RESET = 8'h00;

    typedef struct packed {
        logic [BURST_W-1:0] burst_length_setting;
        logic [1:0] group;
    } spkl_key_cfg_type;

    typedef struct packed {
        logic touched;
        logic [POS_W-1:0] position;
    } spkl_slider_type;

    typedef struct packed {
        logic held;
        logic [4:0] owner;
    } spkl_lock_type;
endpackage

// ---- verification/spkl_touch_model.sv ----
// touch key matrix seen from the readout: per-key detect flags and signal deltas
// assumes the bench names the touched keys; new values land on each rising edge
`timescale 1ns/1ps
module spkl_touch_model (
    input wire logic clk_in,
    input wire logic [15:0] touch_in,
    output logic [15:0] key_detect_out,
    output logic [15:0][spkl_pkg::DELTA_W-1:0] key_delta_out
);
    localparam int TOUCH_BASE = 200;
    localparam int TOUCH_SPAN = 600;
    localparam int IDLE_SPAN = 8;
    // deltas wander every cycle, so a stale value never passes for a fresh one
    always @(posedge clk_in) begin
        for (int i = 0; i < 16; i++) begin
            key_detect_out[i] <= touch_in[i];
            key_delta_out[i] <= spkl_pkg::DELTA_W'(touch_in[i] ?
                TOUCH_BASE + $urandom % TOUCH_SPAN : $urandom % IDLE_SPAN);
        end
    end
endmodule

// ---- verification/tb_spkl_core.sv ----
// self-checking bench for the slider position and key lockout core
// assumes the touch model as far side; a reference model predicts every cycle
`timescale 1ns/1ps
module tb_spkl_core;
    logic clk_in, srst_in, sv, sl_en, rv;
    logic [3:0] sl_keys, sl_res;
    logic [15:0] touch, det, st_out, e_st;
    logic [15:0][spkl_pkg::DELTA_W-1:0] dl;
    spkl_pkg::spkl_key_cfg_type [15:0] cfg;
    spkl_pkg::spkl_slider_type sl_out;
    logic [7:0] e_pos;
    logic e_touch, e_valid;
    logic [4:0] own [1:3];
    logic hold [1:3];
    int err_total = 0;
    int samples_checked = 0;

    spkl_touch_model pad (.clk_in(clk_in), .touch_in(touch), .key_detect_out(det),
        .key_delta_out(dl));
    spkl_core uut (.clk_in(clk_in), .srst_in(srst_in), .sample_valid_in(sv),
        .key_detect_in(det), .key_delta_in(dl), .key_cfg_in(cfg), .slider_enable_in(sl_en),
        .slider_keys_in(sl_keys), .slider_res_bits_in(sl_res), .key_state_out(st_out),
        .slider_out(sl_out), .report_valid_out(rv));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // reference: one acquisition cycle as seen at the sampling edge
    task automatic ref_step();
        int len, mx, best, bd, sd, o;
        logic [15:0] en, mem, st;
        logic sdet, srep;
        longint num, sum;
        len = sl_keys < 2 ? 2 : (sl_keys > 8 ? 8 : sl_keys);
        mx = (1 << (sl_res < 2 ? 2 : (sl_res > 8 ? 8 : sl_res))) - 1;
        mem = '0; sdet = 0; sd = 0; st = '0; num = 0; sum = 0;
        for (int i = 0; i < 16; i++) begin
            en[i] = cfg[i].burst_length_setting != 4'h0;
            mem[i] = sl_en && i < len && en[i];
            if (mem[i] && det[i]) begin
                sdet = 1;
                if (dl[i] > sd) sd = dl[i];
            end
            if (en[i] && !mem[i] && det[i] && cfg[i].group == 2'h0) st[i] = 1;
        end
        srep = sdet && cfg[0].group == 2'h0;
        for (int g = 1; g <= 3; g++) begin
            o = own[g];
            if (hold[g]) hold[g] = (o == 16) ? sdet && cfg[0].group == g :
                det[o] && en[o] && !mem[o] && cfg[o].group == g;
            if (!hold[g]) begin
                best = -1; bd = 0;
                for (int i = 0; i < 16; i++)
                    if (det[i] && en[i] && !mem[i] && cfg[i].group == g && (best < 0 || dl[i] > bd)) begin
                        best = i; bd = dl[i];
                    end
                if (sdet && cfg[0].group == g && (best < 0 || sd > bd)) best = 16;
                if (best >= 0) begin
                    hold[g] = 1; own[g] = 5'(best);
                end
            end
            if (hold[g] && own[g] == 5'h10) srep = 1;
            else if (hold[g]) st[own[g]] = 1;
        end
        if (srep) begin
            st = st | (mem & det);
            for (int i = 0; i < 16; i++)
                if (mem[i]) begin
                    num += i * dl[i]; sum += dl[i];
                end
            e_pos = sum == 0 ? 8'h00 : 8'(num * mx / ((len - 1) * sum) > mx ? mx :
                num * mx / ((len - 1) * sum));
        end
        e_touch = srep;
        e_st = st;
    endtask

    always @(posedge clk_in) begin
        e_valid = sv && !srst_in;
        if (srst_in) begin
            e_st = '0; e_pos = 8'h00; e_touch = 0;
            for (int g = 1; g <= 3; g++) hold[g] = 0;
        end else if (sv) ref_step();
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    always @(negedge clk_in) begin
        check("key_state_out", 32'(e_st), 32'(st_out));
        check("slider_out", 32'({e_valid, e_touch, e_pos}), 32'({rv, sl_out}));
    end

    task automatic samp(input logic [15:0] t);
        touch <= t;
        @(posedge clk_in);
        sv <= 1'b1;
        @(posedge clk_in);
        sv <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic finish_test();
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        srst_in = 1'b1; sv = 1'b0; touch = 16'h0000; sl_en = 1'b1; sl_keys = 4'h4; sl_res = 4'h8;
        for (int i = 0; i < 16; i++) cfg[i] = '{burst_length_setting: 4'h5, group: 2'h1};
        void'($urandom(32'hC2CD87EC));
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        // key first, then slider joins, then key lifts; slider first, then key
        samp(16'h0400);
        samp(16'h0403);
        samp(16'h0003);
        samp(16'h0403);
        cfg[12].group <= 2'h0;
        cfg[9].group <= 2'h2;
        cfg[11].group <= 2'h2;
        samp(16'h1A03);
        cfg[1].burst_length_setting <= 4'h0;
        samp(16'h0007);
        for (int l = 0; l < 16; l++)
            for (int r = 0; r < 16; r++) begin
                sl_keys <= 4'(l);
                sl_res <= 4'(r);
                samp(16'($urandom) & 16'h00FF);
            end
        sl_en <= 1'b0;
        samp(16'h00FF);
        sv <= 1'b1;
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        sl_en <= 1'b1;
        // random traffic, samples often back to back, config reshuffled now and then
        repeat (4000) begin
            @(posedge clk_in);
            touch <= 16'($urandom & $urandom & $urandom);
            sv <= 1'($urandom);
            if ($urandom % 40 == 0) begin
                for (int i = 0; i < 16; i++)
                    cfg[i] <= '{burst_length_setting: 4'($urandom % 6), group: 2'($urandom)};
                sl_en <= 1'($urandom % 4 != 0);
                sl_keys <= 4'($urandom);
                sl_res <= 4'($urandom);
            end
        end
        sv <= 1'b0;
        repeat (3) @(posedge clk_in);
        finish_test();
    end
endmodule
